// File: pkg/rfp_pkg.sv
// shared constants and types of the rail fault protection block
// assumes one 100 MHz clock and comparator results synchronous to it
package rfp_pkg;

	// clock and filter timing
	localparam int CLK_PERIOD_NS       = 10;
	localparam int OV_DELAY_NS         = 1000;
	localparam int UV_DELAY_NS         = 3000;
	localparam int LOCKOUT_DELAY_NS    = 3000;

	// least time rounds up, never below one cycle
	function automatic int rfp_min_cycles(input int time_ns);
		int cyc;
		cyc = (time_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (cyc < 1) ? 1 : cyc;
	endfunction

	localparam int OV_DELAY_CYC        = rfp_min_cycles(OV_DELAY_NS);
	localparam int UV_DELAY_CYC        = rfp_min_cycles(UV_DELAY_NS);
	localparam int LOCKOUT_DELAY_CYC   = rfp_min_cycles(LOCKOUT_DELAY_NS);

	// widths and defaults
	localparam int VID_W               = 8;
	localparam int NUM_PHASES_DEF      = 2;
	localparam logic [VID_W-1:0] VID_0V9_CODE_DEF = 8'h5a;

	typedef enum logic [2:0] {
		RFP_ST_IDLE     = 3'h0,
		RFP_ST_RUN      = 3'h1,
		RFP_ST_OV_LATCH = 3'h2,
		RFP_ST_OV_NEG   = 3'h3,
		RFP_ST_UV_LATCH = 3'h4,
		RFP_ST_LOCKOUT  = 3'h5
	} rfp_state_t;

	typedef enum logic [1:0] {
		RFP_GATE_PWM     = 2'h0,
		RFP_GATE_OV_SAFE = 2'h1,
		RFP_GATE_ALL_OFF = 2'h2
	} rfp_gate_mode_t;

endpackage

// File: pkg/rfp_gate_if.sv
// gate command path between the protection controller and the gate stage
// assumes both ends share clock_in
`timescale 1ns/1ns
interface rfp_gate_if
	import rfp_pkg::*;
#(
	parameter int NUM_PHASES = NUM_PHASES_DEF
);
	rfp_gate_mode_t        mode;
	logic [NUM_PHASES-1:0] active_phases;

	modport ctrl  (output mode, output active_phases);
	modport stage (input  mode, input  active_phases);
endinterface

// File: rtl/rfp_deglitch.sv
// persistence filter for one comparator result
// assumes raw_in synchronous to clock_in
`timescale 1ns/1ns
module rfp_deglitch
	import rfp_pkg::*;
#(
	parameter int COUNT = OV_DELAY_CYC
)(
	input  wire logic clock_in,
	input  wire logic reset_in,
	input  wire logic clear_in,
	input  wire logic raw_in,
	output logic      fire_out
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          fire;
	} rfp_dg_state_t;

	rfp_dg_state_t st_r;
	rfp_dg_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (clear_in || !raw_in) begin
			st_nxt.cnt  = '0;
			st_nxt.fire = 1'b0;
		end else if (st_r.cnt < LAST) begin
			st_nxt.cnt = st_r.cnt + CW'(1);
		end else begin
			st_nxt.fire = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign fire_out = st_r.fire;
endmodule

// File: rtl/rfp_gate_stage.sv
// per-phase gate enables from pwm requests and the protection mode
// assumes pwm requests synchronous to clock_in
`timescale 1ns/1ns
module rfp_gate_stage
	import rfp_pkg::*;
#(
	parameter int NUM_PHASES = NUM_PHASES_DEF
)(
	input  wire logic                  clock_in,
	input  wire logic                  reset_in,
	rfp_gate_if.stage                  gate,
	input  wire logic [NUM_PHASES-1:0] pwm_hs_in,
	input  wire logic [NUM_PHASES-1:0] pwm_ls_in,
	output logic      [NUM_PHASES-1:0] hs_enable_out,
	output logic      [NUM_PHASES-1:0] ls_enable_out
);
	typedef struct packed {
		logic [NUM_PHASES-1:0] hs;
		logic [NUM_PHASES-1:0] ls;
	} rfp_gs_state_t;

	rfp_gs_state_t         st_r;
	rfp_gs_state_t         st_nxt;
	logic [NUM_PHASES-1:0] hs_nxt;
	logic [NUM_PHASES-1:0] ls_nxt;

	for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
		always_comb begin
			hs_nxt[p] = 1'b0;
			ls_nxt[p] = 1'b0;
			if (gate.active_phases[p]) begin
				unique case (gate.mode)
					RFP_GATE_PWM: begin
						hs_nxt[p] = pwm_hs_in[p];
						ls_nxt[p] = pwm_ls_in[p] & ~pwm_hs_in[p];
					end
					RFP_GATE_OV_SAFE: begin
						ls_nxt[p] = 1'b1;
					end
					RFP_GATE_ALL_OFF: begin
						ls_nxt[p] = 1'b0;
					end
					default: begin
						ls_nxt[p] = 1'b0;
					end
				endcase
			end
		end
	end

	always_comb begin
		st_nxt.hs = hs_nxt;
		st_nxt.ls = ls_nxt;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hs_enable_out = st_r.hs;
	assign ls_enable_out = st_r.ls;
endmodule

// File: rtl/rfp_rail_protect.sv
// fault protection sequencer for the northbridge rail
// assumes comparator results and supply flags are synchronous to clock_in
// and that reset_in is the power-on reset of the controller
`timescale 1ns/1ns

module rfp_rail_protect
	import rfp_pkg::*;
#(
	parameter int               NUM_PHASES   = NUM_PHASES_DEF,
	parameter logic [VID_W-1:0] VID_0V9_CODE = VID_0V9_CODE_DEF
)(
	input  wire logic                  clock_in,
	input  wire logic                  reset_in,
	input  wire logic                  enable_in,
	input  wire logic [VID_W-1:0]      commanded_voltage_code_in,
	input  wire logic                  rail_sense_above_fixed_in,
	input  wire logic                  rail_sense_above_ref_in,
	input  wire logic                  rail_sense_below_ref_in,
	input  wire logic                  rail_sense_below_ground_in,
	input  wire logic                  main_supply_low_in,
	input  wire logic                  driver_supply_input_low_in,
	input  wire logic [NUM_PHASES-1:0] active_phases_in,
	input  wire logic [NUM_PHASES-1:0] pwm_hs_in,
	input  wire logic [NUM_PHASES-1:0] pwm_ls_in,
	output logic      [NUM_PHASES-1:0] hs_enable_out,
	output logic      [NUM_PHASES-1:0] ls_enable_out,
	output logic                       overvoltage_trip_out,
	output logic                       undervoltage_trip_out,
	output logic                       below_ground_trip_out,
	output logic                       supply_low_lockout_out,
	output logic                       other_rail_shutdown_out,
	output logic                       monitor_active_out
);

	typedef struct packed {
		rfp_state_t            state;
		logic                  ov_latch;
		logic                  uv_latch;
		logic                  enable_prev;
		logic                  other_shutdown;
		logic [NUM_PHASES-1:0] phases;
	} rfp_ctl_state_t;

	rfp_ctl_state_t st_r;
	rfp_ctl_state_t st_nxt;

	// command at or below the 0.9V code uses the fixed trip level
	function automatic logic vid_uses_fixed(input logic [VID_W-1:0] code);
		return code <= VID_0V9_CODE;
	endfunction

	function automatic logic state_is_operating(input rfp_state_t s);
		return (s != RFP_ST_IDLE) && (s != RFP_ST_LOCKOUT);
	endfunction

	logic ov_raw;
	logic uv_raw;
	logic supply_raw;
	logic ov_fire;
	logic uv_fire;
	logic lockout_fire;
	logic ov_clear;
	logic uv_clear;
	logic lockout_clear;
	logic enable_rise;

	// over-voltage source chosen from the commanded code
	always_comb begin
		if (vid_uses_fixed(commanded_voltage_code_in)) begin
			ov_raw = rail_sense_above_fixed_in;
		end else begin
			ov_raw = rail_sense_above_ref_in;
		end
	end

	assign uv_raw        = rail_sense_below_ref_in;
	assign supply_raw    = main_supply_low_in | driver_supply_input_low_in;
	assign ov_clear      = (st_r.state != RFP_ST_RUN) && (st_r.state != RFP_ST_UV_LATCH);
	assign uv_clear      = (st_r.state != RFP_ST_RUN);
	assign lockout_clear = !state_is_operating(st_r.state);
	assign enable_rise   = enable_in && !st_r.enable_prev;

	rfp_deglitch #(
		.COUNT (OV_DELAY_CYC)
	) u_ov_filter (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.clear_in (ov_clear),
		.raw_in   (ov_raw),
		.fire_out (ov_fire)
	);

	rfp_deglitch #(
		.COUNT (UV_DELAY_CYC)
	) u_uv_filter (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.clear_in (uv_clear),
		.raw_in   (uv_raw),
		.fire_out (uv_fire)
	);

	rfp_deglitch #(
		.COUNT (LOCKOUT_DELAY_CYC)
	) u_lockout_filter (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.clear_in (lockout_clear),
		.raw_in   (supply_raw),
		.fire_out (lockout_fire)
	);

	always_comb begin
		st_nxt             = st_r;
		st_nxt.enable_prev = enable_in;
		st_nxt.phases      = active_phases_in;

		// fresh enable clears both latches, except in lockout
		if (enable_rise && (st_r.state != RFP_ST_LOCKOUT)) begin
			st_nxt.ov_latch = 1'b0;
			st_nxt.uv_latch = 1'b0;
		end

		unique case (st_r.state)
			RFP_ST_IDLE: begin
				if (enable_in) begin
					st_nxt.state = RFP_ST_RUN;
				end
			end
			RFP_ST_RUN: begin
				if (lockout_fire) begin
					st_nxt.state = RFP_ST_LOCKOUT;
				end else if (ov_fire) begin
					st_nxt.state    = RFP_ST_OV_LATCH;
					st_nxt.ov_latch = 1'b1;
				end else if (uv_fire) begin
					st_nxt.state    = RFP_ST_UV_LATCH;
					st_nxt.uv_latch = 1'b1;
				end else if (!enable_in) begin
					st_nxt.state = RFP_ST_IDLE;
				end
			end
			RFP_ST_OV_LATCH: begin
				if (lockout_fire) begin
					st_nxt.state = RFP_ST_LOCKOUT;
				end else if (enable_rise) begin
					st_nxt.state = RFP_ST_RUN;
				end else if (rail_sense_below_ground_in) begin
					st_nxt.state = RFP_ST_OV_NEG;
				end
			end
			RFP_ST_OV_NEG: begin
				if (lockout_fire) begin
					st_nxt.state = RFP_ST_LOCKOUT;
				end else if (enable_rise) begin
					st_nxt.state = RFP_ST_RUN;
				end else if (!rail_sense_below_ground_in) begin
					st_nxt.state = RFP_ST_OV_LATCH;
				end
			end
			RFP_ST_UV_LATCH: begin
				if (lockout_fire) begin
					st_nxt.state = RFP_ST_LOCKOUT;
				end else if (enable_rise) begin
					st_nxt.state = RFP_ST_RUN;
				end
			end
			RFP_ST_LOCKOUT: begin
				// supplies back: resume any held latch, else go idle
				if (!supply_raw) begin
					if (st_r.ov_latch) begin
						st_nxt.state = RFP_ST_OV_LATCH;
					end else if (st_r.uv_latch) begin
						st_nxt.state = RFP_ST_UV_LATCH;
					end else begin
						st_nxt.state = RFP_ST_IDLE;
					end
				end
			end
			default: begin
				st_nxt.state = RFP_ST_IDLE;
			end
		endcase

		st_nxt.other_shutdown = st_nxt.ov_latch | st_nxt.uv_latch;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	rfp_gate_if #(
		.NUM_PHASES (NUM_PHASES)
	) gate_bus ();

	// gate mode from the registered state
	always_comb begin
		unique case (st_r.state)
			RFP_ST_RUN:      gate_bus.mode = RFP_GATE_PWM;
			RFP_ST_OV_LATCH: gate_bus.mode = RFP_GATE_OV_SAFE;
			RFP_ST_OV_NEG:   gate_bus.mode = RFP_GATE_ALL_OFF;
			RFP_ST_UV_LATCH: gate_bus.mode = RFP_GATE_ALL_OFF;
			RFP_ST_LOCKOUT:  gate_bus.mode = RFP_GATE_ALL_OFF;
			default:         gate_bus.mode = RFP_GATE_ALL_OFF;
		endcase
	end

	assign gate_bus.active_phases = st_r.phases;

	rfp_gate_stage #(
		.NUM_PHASES (NUM_PHASES)
	) u_gate_stage (
		.clock_in      (clock_in),
		.reset_in      (reset_in),
		.gate          (gate_bus.stage),
		.pwm_hs_in     (pwm_hs_in),
		.pwm_ls_in     (pwm_ls_in),
		.hs_enable_out (hs_enable_out),
		.ls_enable_out (ls_enable_out)
	);

	assign overvoltage_trip_out    = st_r.ov_latch;
	assign undervoltage_trip_out   = st_r.uv_latch;
	assign below_ground_trip_out   = (st_r.state == RFP_ST_OV_NEG);
	assign supply_low_lockout_out  = (st_r.state == RFP_ST_LOCKOUT);
	assign other_rail_shutdown_out = st_r.other_shutdown;
	assign monitor_active_out      = state_is_operating(st_r.state);
endmodule

// File: tb/rfp_rail_protect_chk.sv
// port assertions for the rail protection block
// assumes a bind inside rfp_rail_protect, one clock domain
`timescale 1ns/1ns
module rfp_rail_protect_chk
	import rfp_pkg::*;
#(
	parameter int               NUM_PHASES   = NUM_PHASES_DEF,
	parameter logic [VID_W-1:0] VID_0V9_CODE = VID_0V9_CODE_DEF
)(
	input wire logic			clock_in,
	input wire logic			reset_in,
	input wire logic			enable_in,
	input wire logic [VID_W-1:0]		commanded_voltage_code_in,
	input wire logic			rail_sense_above_fixed_in,
	input wire logic			rail_sense_above_ref_in,
	input wire logic			rail_sense_below_ref_in,
	input wire logic			main_supply_low_in,
	input wire logic			driver_supply_input_low_in,
	input wire logic [NUM_PHASES-1:0]	active_phases_in,
	input wire logic [NUM_PHASES-1:0]	hs_enable_out,
	input wire logic [NUM_PHASES-1:0]	ls_enable_out,
	input wire logic			overvoltage_trip_out,
	input wire logic			undervoltage_trip_out,
	input wire logic			below_ground_trip_out,
	input wire logic			supply_low_lockout_out,
	input wire logic			other_rail_shutdown_out
);
	logic	ov_raw;
	int	ov_n_r, uv_n_r, sl_n_r;
	assign ov_raw = (commanded_voltage_code_in <= VID_0V9_CODE) ? rail_sense_above_fixed_in
		: rail_sense_above_ref_in;
	// unbroken run length of the raw over-voltage, under-voltage and supply-low conditions
	always_ff @(posedge clock_in) begin
		ov_n_r <= (reset_in || !ov_raw) ? 0 : ov_n_r + 1;
		uv_n_r <= (reset_in || !rail_sense_below_ref_in) ? 0 : uv_n_r + 1;
		sl_n_r <= (reset_in || !(main_supply_low_in || driver_supply_input_low_in)) ? 0 : sl_n_r + 1;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	ov_delay_a: assert property ($rose(overvoltage_trip_out) |-> $past(ov_n_r) >= OV_DELAY_CYC)
		else $error("over-voltage latched too early");
	uv_delay_a: assert property ($rose(undervoltage_trip_out) |-> $past(uv_n_r) >= UV_DELAY_CYC)
		else $error("under-voltage latched too early");
	lock_delay_a: assert property ($rose(supply_low_lockout_out) |-> $past(sl_n_r) >= LOCKOUT_DELAY_CYC)
		else $error("lockout entered too early");
	ov_safe_gates_a: assert property (overvoltage_trip_out && !below_ground_trip_out
		&& !supply_low_lockout_out |=> hs_enable_out == '0 && ls_enable_out == $past(active_phases_in, 2))
		else $error("gates not in over-voltage safe state");
	neg_gates_off_a: assert property (below_ground_trip_out |=> hs_enable_out == '0 && ls_enable_out == '0)
		else $error("gates on under negative protection");
	neg_needs_ov_a: assert property (below_ground_trip_out |-> overvoltage_trip_out)
		else $error("negative protection without over-voltage latch");
	uv_gates_off_a: assert property (undervoltage_trip_out |=> hs_enable_out == '0 && ls_enable_out == '0)
		else $error("gates on under under-voltage latch");
	lock_gates_off_a: assert property (supply_low_lockout_out |=> !(|{hs_enable_out, ls_enable_out}))
		else $error("gates on in lockout");
	shutdown_req_a: assert property (other_rail_shutdown_out == (overvoltage_trip_out || undervoltage_trip_out))
		else $error("other rail shutdown request wrong");
	ov_latch_hold_a: assert property (overvoltage_trip_out && !(enable_in && !$past(enable_in))
		|=> overvoltage_trip_out)
		else $error("over-voltage latch dropped");
endmodule

// File: tb/rfp_drv_model.sv
// pwm source and gate driver stand-in for the rail phases
// assumes gate enables registered on clock_in
`timescale 1ns/1ns
module rfp_drv_model
	import rfp_pkg::*;
#(
	parameter int NUM_PHASES = NUM_PHASES_DEF
)(
	input wire logic			clock_in,
	input wire logic			reset_in,
	input wire logic [NUM_PHASES-1:0]	hs_enable_in,
	input wire logic [NUM_PHASES-1:0]	ls_enable_in,
	output logic [NUM_PHASES-1:0]		pwm_hs_out,
	output logic [NUM_PHASES-1:0]		pwm_ls_out,
	output logic				overlap_out
);
	logic [3:0] cnt_r;
	always_ff @(posedge clock_in) begin
		cnt_r <= reset_in ? 4'h0 : cnt_r + 4'h1;
		// sticky: both switches of one phase on
		if (reset_in)
			overlap_out <= 1'b0;
		else if (|(hs_enable_in & ls_enable_in))
			overlap_out <= 1'b1;
	end
	// phases interleaved, low side asked whenever high side is not
	always_comb begin
		for (int i = 0; i < NUM_PHASES; i++) begin
			pwm_hs_out[i] = cnt_r[3] ^ i[0];
			pwm_ls_out[i] = ~pwm_hs_out[i];
		end
	end
endmodule

// File: tb/tb.sv
// self-checking bench for the rail protection block
// assumes package defaults and the pwm stand-in model
`timescale 1ns/1ns
module tb;
	import rfp_pkg::*;
	localparam int NP = NUM_PHASES_DEF;
	logic clock_in = 1'b0, reset_in = 1'b1, enable_in = 1'b0;
	logic [VID_W-1:0] commanded_voltage_code_in = 8'h5a;
	logic rail_sense_above_fixed_in = 1'b1, rail_sense_above_ref_in = 1'b0;
	logic rail_sense_below_ref_in = 1'b0, rail_sense_below_ground_in = 1'b0;
	logic main_supply_low_in = 1'b0, driver_supply_input_low_in = 1'b0;
	logic [NP-1:0] active_phases_in = 2'h3, pwm_hs_in, pwm_ls_in, hs_enable_out, ls_enable_out;
	logic overvoltage_trip_out, undervoltage_trip_out, below_ground_trip_out, supply_low_lockout_out;
	logic other_rail_shutdown_out, monitor_active_out, overlap;
	int n_mismatch = 0, total_checks = 0, cycles = 0;

	always #5 clock_in = ~clock_in;

	rfp_rail_protect dut (.clock_in, .reset_in, .enable_in, .commanded_voltage_code_in,
		.rail_sense_above_fixed_in, .rail_sense_above_ref_in, .rail_sense_below_ref_in,
		.rail_sense_below_ground_in, .main_supply_low_in, .driver_supply_input_low_in,
		.active_phases_in, .pwm_hs_in, .pwm_ls_in, .hs_enable_out, .ls_enable_out,
		.overvoltage_trip_out, .undervoltage_trip_out, .below_ground_trip_out,
		.supply_low_lockout_out, .other_rail_shutdown_out, .monitor_active_out);

	rfp_drv_model #(.NUM_PHASES(NP)) drv (.clock_in, .reset_in, .hs_enable_in(hs_enable_out),
		.ls_enable_in(ls_enable_out), .pwm_hs_out(pwm_hs_in), .pwm_ls_out(pwm_ls_in), .overlap_out(overlap));

	task automatic finish_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		total_checks++;
		if (a !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, a, e);
		end
	endtask

	task automatic setr(input int k, input logic v);
		case (k)
			0: rail_sense_above_fixed_in = v;
			1: rail_sense_above_ref_in = v;
			2: rail_sense_below_ref_in = v;
			3: rail_sense_below_ground_in = v;
			4: main_supply_low_in = v;
			default: driver_supply_input_low_in = v;
		endcase
	endtask

	function automatic logic st(input int k);
		return k == 0 ? overvoltage_trip_out : k == 1 ? undervoltage_trip_out : supply_low_lockout_out;
	endfunction

	// edges until the status output k goes high
	task automatic run_to(input int k, output int n);
		n = 0;
		while (st(k) !== 1'b1 && n < 1000) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic fresh;
		enable_in = 1'b0;
		cyc(1);
		enable_in = 1'b1;
		cyc(2);
	endtask

	// k 0: fixed level at code boundary, k 1: reference above it
	task automatic t_ov(input int k);
		int n;
		commanded_voltage_code_in = k ? 8'h5b : 8'h5a;
		active_phases_in = k ? 2'h2 : 2'h3;
		setr(1 - k, 1'b1);
		setr(3, 1'b1);
		cyc(OV_DELAY_CYC + 5);
		chk(overvoltage_trip_out, 1'b0);
		chk(below_ground_trip_out, 1'b0);
		setr(1 - k, 1'b0);
		setr(3, 1'b0);
		setr(k, 1'b1);
		cyc(OV_DELAY_CYC - 1);
		setr(k, 1'b0);
		cyc(1);
		setr(k, 1'b1);
		run_to(0, n);
		chk(n, OV_DELAY_CYC + 1);
		chk(other_rail_shutdown_out, 1'b1);
		cyc(1);
		chk(hs_enable_out, '0);
		chk(ls_enable_out, active_phases_in);
		setr(3, 1'b1);
		cyc(2);
		chk(below_ground_trip_out, 1'b1);
		chk({hs_enable_out, ls_enable_out}, '0);
		setr(3, 1'b0);
		cyc(2);
		chk(ls_enable_out, active_phases_in);
		setr(k, 1'b0);
		cyc(5);
		chk(overvoltage_trip_out, 1'b1);
		fresh();
		chk(overvoltage_trip_out, 1'b0);
	endtask

	task automatic t_uv;
		int n;
		setr(2, 1'b1);
		cyc(UV_DELAY_CYC - 1);
		setr(2, 1'b0);
		cyc(1);
		chk(undervoltage_trip_out, 1'b0);
		setr(2, 1'b1);
		run_to(1, n);
		chk(n, UV_DELAY_CYC + 1);
		chk(other_rail_shutdown_out, 1'b1);
		cyc(1);
		chk({hs_enable_out, ls_enable_out}, '0);
		setr(2, 1'b0);
		fresh();
		chk(undervoltage_trip_out, 1'b0);
	endtask

	// power-on reset in mid-run drops a held latch
	task automatic t_por;
		int n;
		setr(2, 1'b1);
		run_to(1, n);
		chk(n, UV_DELAY_CYC + 1);
		reset_in = 1'b1;
		setr(2, 1'b0);
		cyc(2);
		chk({undervoltage_trip_out, other_rail_shutdown_out, monitor_active_out}, '0);
		reset_in = 1'b0;
		cyc(2);
		chk(monitor_active_out, 1'b1);
		chk(undervoltage_trip_out, 1'b0);
	endtask

	task automatic t_lock(input int k);
		int n;
		setr(k, 1'b1);
		run_to(2, n);
		chk(n, LOCKOUT_DELAY_CYC + 1);
		cyc(1);
		chk({hs_enable_out, ls_enable_out}, '0);
		chk(monitor_active_out, 1'b0);
		setr(k, 1'b0);
		cyc(2);
		chk(supply_low_lockout_out, 1'b0);
		fresh();
	endtask

	initial begin
		cyc(2);
		chk(overvoltage_trip_out, 1'b0);
		chk(monitor_active_out, 1'b0);
		reset_in = 1'b0;
		rail_sense_above_fixed_in = 1'b0;
		enable_in = 1'b1;
		cyc(3);
		chk(monitor_active_out, 1'b1);
		t_ov(0);
		t_ov(1);
		t_uv();
		t_por();
		t_lock(4);
		t_lock(5);
		chk(overlap, 1'b0);
		finish_test();
	end
endmodule

bind rfp_rail_protect rfp_rail_protect_chk #(.NUM_PHASES(NUM_PHASES), .VID_0V9_CODE(VID_0V9_CODE)) chk_i (
	.clock_in, .reset_in, .enable_in,
	.commanded_voltage_code_in, .rail_sense_above_fixed_in, .rail_sense_above_ref_in, .rail_sense_below_ref_in,
	.main_supply_low_in, .driver_supply_input_low_in, .active_phases_in, .hs_enable_out, .ls_enable_out,
	.overvoltage_trip_out, .undervoltage_trip_out, .below_ground_trip_out, .supply_low_lockout_out,
	.other_rail_shutdown_out);
